// >>> src/sac_pkg.sv
// Package of constants and types for the conversion-control and parallel-output block
package sac_pkg;
   // ==========================================
   // Widths
   localparam int RESULT_W = 16;
   localparam int HALF_W = 8;
   // ==========================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int BUSY_MAX_NS = 83;
   // Longest time rounds down, at least one cycle
   localparam int BUSY_MAX_CYC = (BUSY_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (BUSY_MAX_NS / CLK_PERIOD_NS);
   localparam int CONV_TIME_NS = 4000;
   localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 12;
   // ==========================================
   // Reset values
   localparam logic [15:0] RESULT_RST = 16'h0000;
   localparam logic [11:0] CNT_RST = 12'h000;
   // ==========================================
   // States
   typedef enum logic [0:0] {SAC_IDLE, SAC_CONV} sac_state_e;
endpackage

// >>> src/sac_top.sv
// Conversion control and three-state parallel result port of a successive-approximation converter
//
// Operation
// - Result lines float while select is high or read_convert_n is low.
// - Bit 15 is the result MSB, bit 0 the LSB.
// - Swap select low: natural lane order.
// - Swap select high: upper and lower bytes exchanged on the lanes.
// - Select low, falling read_convert_n holds the sample and starts conversion.
// - Select low, rising read_convert_n enables the result lines.
// - Select ORed with read_convert_n; select falling with it low starts conversion.
// - read_convert_n high, select falling enables reading, no conversion.
// - Busy low from conversion start until result is latched.
// - Data valid when busy rises with select low, read_convert_n high.
// - Busy falls within 83 ns of conversion start.
// - Commands ignored during a conversion; reads still allowed.
// - Results are two's complement.
`timescale 1ns/1ns
module sac_top #(
   parameter int CONV_CYCLES = sac_pkg::CONV_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Host control pins
   input wire logic unit_select_n,
   input wire logic read_convert_n,
   input wire logic half_swap_select,
   // Sampled code from the analog core, two's complement
   input wire logic [sac_pkg::RESULT_W-1:0] sample_code,
   // Status and result lanes
   output logic busy_n,
   output logic hold_sample,
   output logic [sac_pkg::RESULT_W-1:0] result_bits,
   output logic [sac_pkg::RESULT_W-1:0] result_bits_oe_n
);
   import sac_pkg::*;

   // ==========================================
   // Pin synchronisers
   logic cs_s1_reg, cs_s2_reg, rc_s1_reg, rc_s2_reg, sw_s1_reg, sw_s2_reg;
   logic [RESULT_W-1:0] code_s1_reg, code_s2_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         rc_s1_reg <= 1'b1;
         rc_s2_reg <= 1'b1;
         sw_s1_reg <= 1'b0;
         sw_s2_reg <= 1'b0;
         code_s1_reg <= RESULT_RST;
         code_s2_reg <= RESULT_RST;
      end else begin
         cs_s1_reg <= unit_select_n;
         cs_s2_reg <= cs_s1_reg;
         rc_s1_reg <= read_convert_n;
         rc_s2_reg <= rc_s1_reg;
         sw_s1_reg <= half_swap_select;
         sw_s2_reg <= sw_s1_reg;
         code_s1_reg <= sample_code;
         code_s2_reg <= code_s1_reg;
      end
   end

   // ==========================================
   // Start detection
   // Combined low level of both inputs; a fall of either with the other low starts
   logic both_low_prev_reg;
   wire both_low = ~cs_s2_reg & ~rc_s2_reg;
   wire start_cmd = both_low & ~both_low_prev_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         both_low_prev_reg <= 1'b0;
      end else begin
         both_low_prev_reg <= both_low;
      end
   end

   // ==========================================
   // Conversion sequencer
   sac_state_e state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [RESULT_W-1:0] result_reg, result_next;
   logic [RESULT_W-1:0] held_reg, held_next;
   wire conv_done = (state_reg == SAC_CONV) && (cnt_reg == CNT_W'(CONV_CYCLES - 1));

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      result_next = result_reg;
      held_next = held_reg;
      case (state_reg)
         SAC_IDLE: begin
            if (start_cmd) begin
               // Freeze the sampled code at the hold instant
               held_next = code_s2_reg;
               cnt_next = CNT_RST;
               state_next = SAC_CONV;
            end
         end
         SAC_CONV: begin
            // Further starts ignored here; reads are not affected
            if (conv_done) begin
               result_next = held_reg;
               state_next = SAC_IDLE;
            end else begin
               cnt_next = cnt_reg + CNT_W'(1);
            end
         end
         default: state_next = SAC_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= SAC_IDLE;
         cnt_reg <= CNT_RST;
         result_reg <= RESULT_RST;
         held_reg <= RESULT_RST;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         result_reg <= result_next;
         held_reg <= held_next;
      end
   end

   // Busy and hold come straight from state: busy low, hold high the cycle after start is seen
   assign busy_n = (state_reg == SAC_IDLE);
   assign hold_sample = (state_reg == SAC_CONV);

   // ==========================================
   // Output lanes
   // Swap acts on routing only; stored result never depends on it
   // Fed from the next result so the lanes turn over on the edge busy rises
   wire [RESULT_W-1:0] lane_data = sw_s2_reg ?
      {result_next[HALF_W-1:0], result_next[RESULT_W-1:HALF_W]} :
      result_next;
   wire drive_en = ~cs_s2_reg & rc_s2_reg;

   logic [RESULT_W-1:0] out_reg;
   logic oe_n_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_reg <= RESULT_RST;
         oe_n_reg <= 1'b1;
      end else begin
         out_reg <= lane_data;
         oe_n_reg <= ~drive_en;
      end
   end
   assign result_bits = out_reg;
   assign result_bits_oe_n = {RESULT_W{oe_n_reg}};

   // ==========================================
   // Check helpers
   // Length of the current busy-low stretch, cleared while idle
   logic [CNT_W-1:0] busy_len_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_len_reg <= CNT_RST;
      end else if (!busy_n) begin
         busy_len_reg <= busy_len_reg + CNT_W'(1);
      end else begin
         busy_len_reg <= CNT_RST;
      end
   end

   // ==========================================
   // Checks
   property p_float;
      @(posedge clk) disable iff (!nrst)
      (cs_s2_reg | ~rc_s2_reg) |=> result_bits_oe_n == {RESULT_W{1'b1}};
   endproperty
   a_float: assert property (p_float) else $error("result lines driven while disabled");

   property p_drive;
      @(posedge clk) disable iff (!nrst)
      (~cs_s2_reg & rc_s2_reg) |=> result_bits_oe_n == {RESULT_W{1'b0}};
   endproperty
   a_drive: assert property (p_drive) else $error("result lines not driven on read");

   property p_natural;
      @(posedge clk) disable iff (!nrst)
      !sw_s2_reg |=> result_bits == $past(result_next);
   endproperty
   a_natural: assert property (p_natural) else $error("natural lane order wrong");

   property p_swap;
      @(posedge clk) disable iff (!nrst)
      sw_s2_reg |=> result_bits[7:0] == $past(result_next[15:8]) && result_bits[15:8] == $past(result_next[7:0]);
   endproperty
   a_swap: assert property (p_swap) else $error("swapped lane order wrong");

   property p_busy_fall;
      @(posedge clk) disable iff (!nrst)
      (start_cmd && busy_n) |-> ##[1:8] !busy_n;
   endproperty
   a_busy_fall: assert property (p_busy_fall) else $error("busy late after start");

   property p_ignore;
      @(posedge clk) disable iff (!nrst)
      (!busy_n && start_cmd && !conv_done) |=> !busy_n && $stable(result_reg);
   endproperty
   a_ignore: assert property (p_ignore) else $error("start honoured during conversion");

   property p_keep;
      @(posedge clk) disable iff (!nrst)
      !conv_done |=> $stable(result_reg);
   endproperty
   a_keep: assert property (p_keep) else $error("result changed outside completion");

   property p_busy_rise;
      @(posedge clk) disable iff (!nrst)
      conv_done |=> busy_n && result_reg == $past(held_reg);
   endproperty
   a_busy_rise: assert property (p_busy_rise) else $error("busy rose without latched result");

   property p_swap_store;
      @(posedge clk) disable iff (!nrst)
      ($changed(sw_s2_reg) && !conv_done && !start_cmd) |=> $stable(result_reg) && $stable(state_reg);
   endproperty
   a_swap_store: assert property (p_swap_store) else $error("swap select disturbed state");

   property p_valid_rise;
      @(posedge clk) disable iff (!nrst)
      $rose(busy_n) |-> result_bits == ($past(sw_s2_reg) ?
         {result_reg[HALF_W-1:0], result_reg[RESULT_W-1:HALF_W]} : result_reg);
   endproperty
   a_valid_rise: assert property (p_valid_rise) else $error("result lanes stale when busy rose");

   property p_start_rc;
      @(posedge clk) disable iff (!nrst)
      ($fell(rc_s2_reg) && !cs_s2_reg && busy_n) |=> !busy_n && hold_sample;
   endproperty
   a_start_rc: assert property (p_start_rc) else $error("read_convert_n fall did not start");

   property p_start_cs;
      @(posedge clk) disable iff (!nrst)
      ($fell(cs_s2_reg) && !rc_s2_reg && busy_n) |=> !busy_n;
   endproperty
   a_start_cs: assert property (p_start_cs) else $error("select fall did not start");

   property p_read_no_start;
      @(posedge clk) disable iff (!nrst)
      ($fell(cs_s2_reg) && rc_s2_reg && busy_n) |=> busy_n;
   endproperty
   a_read_no_start: assert property (p_read_no_start) else $error("read select started a conversion");

   property p_conv_len;
      @(posedge clk) disable iff (!nrst)
      $rose(busy_n) |-> busy_len_reg == CNT_W'(CONV_CYCLES);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("busy low stretch has wrong length");

   property p_cnt_bound;
      @(posedge clk) disable iff (!nrst)
      (state_reg == SAC_CONV) |-> cnt_reg <= CNT_W'(CONV_CYCLES - 1);
   endproperty
   a_cnt_bound: assert property (p_cnt_bound) else $error("conversion counter overran");

   property p_held_stable;
      @(posedge clk) disable iff (!nrst)
      (state_reg == SAC_CONV) |=> $stable(held_reg);
   endproperty
   a_held_stable: assert property (p_held_stable) else $error("held code changed mid conversion");

   property p_capture;
      @(posedge clk) disable iff (!nrst)
      (start_cmd && busy_n) |=> hold_sample && held_reg == $past(code_s2_reg);
   endproperty
   a_capture: assert property (p_capture) else $error("code not held at start");

   property p_busy_cause;
      @(posedge clk) disable iff (!nrst)
      $fell(busy_n) |-> $past(start_cmd);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy fell without a start");

   property p_swap_held;
      @(posedge clk) disable iff (!nrst)
      ($changed(sw_s2_reg) && !start_cmd) |=> $stable(held_reg);
   endproperty
   a_swap_held: assert property (p_swap_held) else $error("swap select disturbed held code");

   property p_read_conv;
      @(posedge clk) disable iff (!nrst)
      (!busy_n && !cs_s2_reg && rc_s2_reg && !conv_done) |=> !busy_n && result_bits_oe_n == {RESULT_W{1'b0}};
   endproperty
   a_read_conv: assert property (p_read_conv) else $error("read during conversion refused");

   property p_out_stable;
      @(posedge clk) disable iff (!nrst)
      (state_reg == SAC_IDLE && $stable(sw_s2_reg)) |=> $stable(result_bits);
   endproperty
   a_out_stable: assert property (p_out_stable) else $error("result lanes changed while idle");

   property p_drive_edge;
      @(posedge clk) disable iff (!nrst)
      ($rose(rc_s2_reg) && !cs_s2_reg) |=> result_bits_oe_n == {RESULT_W{1'b0}};
   endproperty
   a_drive_edge: assert property (p_drive_edge) else $error("read_convert_n rise did not drive");
endmodule

// >>> dv/sac_host.sv
// Host model that drives the converter control pins
`timescale 1ns/1ns
module sac_host (
   // Clock
   input wire logic clk,
   // Control pins
   output logic unit_select_n,
   output logic read_convert_n,
   output logic half_swap_select
);
   initial begin
      unit_select_n = 1'b1;
      read_convert_n = 1'b1;
      half_swap_select = 1'b0;
   end
   // Pins change just after a falling edge, then stand n more cycles
   task automatic pins(input logic cs, input logic rc, input logic sw, input int n);
      @(negedge clk);
      unit_select_n = cs;
      read_convert_n = rc;
      half_swap_select = sw;
      repeat (n) @(negedge clk);
   endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench of the conversion-control block
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
$display("Error t=%0t got %h exp %h", $time, a, e); end end
module testbench;
   import sac_pkg::*;
   localparam int CC = 16;
   logic clk, nrst, cs_n, rc_n, swap, busy_n, hold_sample;
   logic [RESULT_W-1:0] sample_code, result_bits, result_bits_oe_n;
   int n_fail, checks_done;
   sac_top #(.CONV_CYCLES(CC)) u_sac_top (.clk(clk), .nrst(nrst), .unit_select_n(cs_n),
      .read_convert_n(rc_n), .half_swap_select(swap), .sample_code(sample_code), .busy_n(busy_n),
      .hold_sample(hold_sample), .result_bits(result_bits), .result_bits_oe_n(result_bits_oe_n));
   sac_host u_sac_host (.clk(clk), .unit_select_n(cs_n), .read_convert_n(rc_n), .half_swap_select(swap));
   // ==========================================
   // Scenarios
   task automatic settle();
      repeat (4) @(negedge clk);
   endtask
   // Poke reads and retriggers mid-conversion; both must leave the run alone
   task automatic conv(input logic [15:0] code, input logic [15:0] prev, input bit poke);
      int n;
      n = 0;
      while (busy_n !== 1'b0 && n <= BUSY_MAX_CYC) begin
         @(negedge clk);
         n++;
      end
      `CHK(n <= BUSY_MAX_CYC, 1'b1)
      `CHK(hold_sample, 1'b1)
      `CHK(result_bits_oe_n, 16'hffff)
      sample_code = ~code;
      n = 0;
      if (poke) begin
         // One more cycle with both low before the read; busy is already low here
         u_sac_host.pins(1'b0, 1'b0, 1'b0, 0);
         u_sac_host.pins(1'b0, 1'b1, 1'b0, 3);
         `CHK(result_bits_oe_n, 16'h0000)
         `CHK(result_bits, prev)
         u_sac_host.pins(1'b0, 1'b0, 1'b0, 0);
         n = 6;
      end
      while (busy_n === 1'b0 && n < 2 * CC) begin
         @(negedge clk);
         n++;
      end
      `CHK(n, CC)
   endtask
   task automatic t_rc_start();
      sample_code = 16'h8001;
      u_sac_host.pins(1'b0, 1'b1, 1'b0, 4);
      u_sac_host.pins(1'b0, 1'b0, 1'b0, 0);
      conv(16'h8001, 16'h0000, 1'b0);
      u_sac_host.pins(1'b0, 1'b1, 1'b0, 0);
      settle();
      `CHK(result_bits_oe_n, 16'h0000)
      `CHK(result_bits, 16'h8001)
      u_sac_host.pins(1'b0, 1'b1, 1'b1, 0);
      settle();
      `CHK(result_bits, 16'h0180)
   endtask
   task automatic t_cs_start();
      sample_code = 16'h7ffe;
      u_sac_host.pins(1'b1, 1'b0, 1'b0, 4);
      `CHK(result_bits_oe_n, 16'hffff)
      u_sac_host.pins(1'b0, 1'b0, 1'b0, 0);
      conv(16'h7ffe, 16'h8001, 1'b1);
   endtask
   task automatic t_cs_read();
      u_sac_host.pins(1'b1, 1'b1, 1'b1, 4);
      u_sac_host.pins(1'b0, 1'b1, 1'b1, 0);
      settle();
      `CHK(busy_n, 1'b1)
      `CHK(result_bits_oe_n, 16'h0000)
      `CHK(result_bits, 16'hfe7f)
      u_sac_host.pins(1'b0, 1'b1, 1'b0, 0);
      settle();
      `CHK(result_bits, 16'h7ffe)
   endtask
   // Select held low, short convert pulse; new data must stand as busy rises
   task automatic t_busy_valid();
      int n;
      n = 0;
      sample_code = 16'h1234;
      u_sac_host.pins(1'b0, 1'b1, 1'b0, 4);
      u_sac_host.pins(1'b0, 1'b0, 1'b0, 5);
      u_sac_host.pins(1'b0, 1'b1, 1'b0, 0);
      while (busy_n !== 1'b1 && n < 2 * CC) begin
         @(negedge clk);
         n++;
      end
      `CHK(result_bits_oe_n, 16'h0000)
      `CHK(result_bits, 16'h1234)
   endtask
   // ==========================================
   // Control
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #50000;
      n_fail++;
      summarize();
   end
   initial begin
      n_fail = 0;
      checks_done = 0;
      nrst = 1'b0;
      sample_code = 16'h0000;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      settle();
      `CHK(busy_n, 1'b1)
      `CHK(result_bits_oe_n, 16'hffff)
      t_rc_start();
      t_cs_start();
      t_cs_read();
      t_busy_valid();
      summarize();
   end
endmodule
